// [hdl/srdma_pkg.sv]
// What this block does
// - request_spacing 1 waits one idle cycle after a transfer before taking a request.
// - counter reaching zero sets count_done_flag.
// - issuing a transfer-escape end request sets escape_irq_flag.
// - channel and serial status flags clear on a written zero, one is ignored; rx_full_flag and transmit-empty also clear when serviced.
// - access_size 00 makes every channel access one byte wide.
// - xfer_mode_sel 00 selects normal transfer mode.
// - escape request reaches the processor only while escape_irq_on is set.
// - transfer-end request reaches the processor only while count_done_irq_on is set.
// - activation_source 10 starts each transfer on an on-chip peripheral request.
// - clear_source_on_service decides whether servicing clears the peripheral source flag.
// - src_step_mode 10 increments the source address, 00 keeps it fixed.
// - dst_step_mode 00 keeps the destination fixed, 10 increments it.
// - request_source_select 146 picks transmit-empty, 145 picks receive-full.
// - reads use the source address register, writes the destination register, 32 bits.
// - transfer count holds the total, counts down per transfer, ends at zero.
// - a normal reception moves the byte into rx_holding_reg and sets rx_full_flag.
// - a receive-full serviced read of rx_holding_reg clears rx_full_flag when clear_source_on_service is set.
// - clearing rx_on leaves rx_full_flag unchanged.
// - reception while rx_full_flag is set sets overrun_flag and drops the byte.
// - overrun_flag clears only by reading one then writing zero; rx_full_flag also clears on a serviced read.
// - rx_irq_on gates the receive-full and receive-error requests.
// - tx_irq_on gates the transmit-empty request and thus transmit activations.
`default_nettype none
package srdma_pkg;
  // ****************************************
  // register map
  // ****************************************
  localparam int          AW                = 24;
  localparam logic [23:0] ADR_CH0_SRC       = 24'hff_fc00;
  localparam logic [23:0] ADR_CH0_DST       = 24'hff_fc04;
  localparam logic [23:0] ADR_CH0_CNT       = 24'hff_fc0c;
  localparam logic [23:0] ADR_CH0_MODE      = 24'hff_fc14;
  localparam logic [23:0] ADR_CH0_ACTL      = 24'hff_fc18;
  localparam logic [23:0] ADR_CH1_SRC       = 24'hff_fc20;
  localparam logic [23:0] ADR_CH1_DST       = 24'hff_fc24;
  localparam logic [23:0] ADR_CH1_CNT       = 24'hff_fc2c;
  localparam logic [23:0] ADR_CH1_MODE      = 24'hff_fc34;
  localparam logic [23:0] ADR_CH1_ACTL      = 24'hff_fc38;
  localparam logic [23:0] ADR_CH0_RSEL      = 24'hff_fd20;
  localparam logic [23:0] ADR_CH1_RSEL      = 24'hff_fd21;
  localparam logic [23:0] ADR_SER_CTRL      = 24'hff_ff82;
  localparam logic [23:0] ADR_SER_STAT      = 24'hff_ff84;
  // holding registers as seen by the channels
  localparam logic [31:0] ADR_TX_HOLD       = 32'h00ff_ff83;
  localparam logic [31:0] ADR_RX_HOLD       = 32'h00ff_ff85;
  // ****************************************
  // field positions
  // ****************************************
  localparam int B_GO        = 31;
  localparam int B_SPACING   = 26;
  localparam int B_ESC_FLAG  = 17;
  localparam int B_DONE_FLAG = 16;
  localparam int B_SIZE      = 14;
  localparam int B_XMODE     = 12;
  localparam int B_ESC_ON    = 9;
  localparam int B_DONE_ON   = 8;
  localparam int B_ACT_SRC   = 6;
  localparam int B_CLR_SRC   = 5;
  localparam int B_AMS       = 31;
  localparam int B_SRC_STEP  = 20;
  localparam int B_DST_STEP  = 16;
  localparam int B_TX_IRQ    = 7;
  localparam int B_RX_IRQ    = 6;
  localparam int B_TX_ON     = 5;
  localparam int B_RX_ON     = 4;
  localparam int B_TXEND_IRQ = 2;
  localparam int B_TX_EMPTY  = 7;
  localparam int B_RX_FULL   = 6;
  localparam int B_OVERRUN   = 5;
  localparam int B_TX_END    = 2;
  // ****************************************
  // codes
  // ****************************************
  localparam logic [1:0]  SIZE_BYTE   = 2'h0;
  localparam logic [1:0]  XMODE_NORM  = 2'h0;
  localparam logic [1:0]  ACT_PERIPH  = 2'h2;
  localparam logic [1:0]  STEP_FIXED  = 2'h0;
  localparam logic [1:0]  STEP_INC    = 2'h2;
  localparam logic [7:0]  SEL_TX_EMPTY = 8'h92;
  localparam logic [7:0]  SEL_RX_FULL  = 8'h91;
  localparam logic [31:0] ONE_STEP    = 32'h0000_0001;
  localparam logic [31:0] ZERO_WORD   = 32'h0000_0000;

  typedef enum logic [1:0] {
    SRDMA_IDLE = 2'b00,
    SRDMA_RD   = 2'b01,
    SRDMA_WR   = 2'b11,
    SRDMA_GAP  = 2'b10
  } srdma_fsm_t;
endpackage : srdma_pkg
`default_nettype wire

// [hdl/srdma_channels.sv]
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module srdma_channels (
  input  wire logic                      clk_sys,
  input  wire logic                      rst,
  input  wire logic                      clkEn,
  input  wire logic [srdma_pkg::AW-1:0]  regAddr,
  input  wire logic [31:0]               regWrData,
  input  wire logic                      regWr,
  input  wire logic                      regRd,
  output logic      [31:0]               regRdData,
  output logic      [31:0]               memAddr,
  output logic                           memRd,
  output logic                           memWr,
  output logic      [7:0]                memWrData,
  input  wire logic [7:0]                memRdData,
  input  wire logic                      rxDone,
  input  wire logic [7:0]                rxByte,
  input  wire logic                      txTaken,
  input  wire logic                      txLastBit,
  output logic      [7:0]                txHoldData,
  output logic                           txOn,
  output logic                           rxOn,
  output logic                           txEmptyReq,
  output logic                           rxFullReq,
  output logic                           rxErrReq,
  output logic                           txEndReq,
  output logic      [1:0]                chDoneIrq,
  output logic      [1:0]                chEscIrq
);
  import srdma_pkg::*;

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    srdma_fsm_t        fsm;
    logic              cur;
    logic [7:0]        data;
    logic [1:0][31:0]  src;
    logic [1:0][31:0]  dst;
    logic [1:0][31:0]  cnt;
    logic [1:0]        go;
    logic [1:0]        spacing;
    logic [1:0]        escFlag;
    logic [1:0]        doneFlag;
    logic [1:0][1:0]   size;
    logic [1:0][1:0]   xmode;
    logic [1:0]        escOn;
    logic [1:0]        doneOn;
    logic [1:0][1:0]   actSrc;
    logic [1:0]        clrSrc;
    logic [1:0]        addr_mode_sel;
    logic [1:0][1:0]   srcStep;
    logic [1:0][1:0]   dstStep;
    logic [1:0][7:0]   reqSel;
    logic [7:0]        serCtrl;
    logic              txEmpty;
    logic              rxFull;
    logic              overrun;
    logic              txEnd;
    logic              armFull;
    logic              armOver;
    logic [7:0]        txHold;
    logic [7:0]        rxHold;
    logic [31:0]       rdData;
    logic [31:0]       mAddr;
    logic              mRd;
    logic              mWr;
    logic [7:0]        mWrData;
    logic [3:0]        reqOut;
    logic [1:0]        doneIrq;
    logic [1:0]        escIrq;
  } srdma_state_t;

  srdma_state_t s_r;
  srdma_state_t s_nxt;

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [31:0] stepAddr(input logic [31:0] a, input logic [1:0] mode);
    stepAddr = (mode == STEP_INC) ? a + ONE_STEP : a;
  endfunction : stepAddr

  function automatic logic [31:0] modeWord(input srdma_state_t s, input int c);
    modeWord = ZERO_WORD;
    modeWord[B_GO]            = s.go[c];
    modeWord[B_SPACING]       = s.spacing[c];
    modeWord[B_ESC_FLAG]      = s.escFlag[c];
    modeWord[B_DONE_FLAG]     = s.doneFlag[c];
    modeWord[B_SIZE+:2]       = s.size[c];
    modeWord[B_XMODE+:2]      = s.xmode[c];
    modeWord[B_ESC_ON]        = s.escOn[c];
    modeWord[B_DONE_ON]       = s.doneOn[c];
    modeWord[B_ACT_SRC+:2]    = s.actSrc[c];
    modeWord[B_CLR_SRC]       = s.clrSrc[c];
  endfunction : modeWord

  function automatic logic [31:0] actlWord(input srdma_state_t s, input int c);
    actlWord = ZERO_WORD;
    actlWord[B_AMS]           = s.addr_mode_sel[c];
    actlWord[B_SRC_STEP+:2]   = s.srcStep[c];
    actlWord[B_DST_STEP+:2]   = s.dstStep[c];
  endfunction : actlWord

  // ****************************************
  // request routing
  // ****************************************
  logic       txReqLive;
  logic       rxReqLive;
  logic [1:0] chReady;

  always_comb begin
    txReqLive = s_r.txEmpty && s_r.serCtrl[B_TX_IRQ];
    rxReqLive = s_r.rxFull && s_r.serCtrl[B_RX_IRQ];
    for (int c = 0; c < 2; c++) begin
      chReady[c] = s_r.go[c]
                   && s_r.actSrc[c] == ACT_PERIPH
                   && s_r.xmode[c] == XMODE_NORM
                   && s_r.size[c] == SIZE_BYTE
                   && !s_r.addr_mode_sel[c]
                   && ((s_r.reqSel[c] == SEL_TX_EMPTY && txReqLive)
                       || (s_r.reqSel[c] == SEL_RX_FULL && rxReqLive));
    end
  end

  // ****************************************
  // next state
  // ****************************************
  logic        pick;
  logic [7:0]  rdByte;
  logic [31:0] wData;

  always_comb begin
    s_nxt       = s_r;
    pick        = 1'b0;
    rdByte      = 8'h00;
    wData       = regWrData;
    s_nxt.mRd   = 1'b0;
    s_nxt.mWr   = 1'b0;
    s_nxt.rdData = ZERO_WORD;

    // register reads: data stand one cycle, status read arms the clear
    if (regRd) begin
      case (regAddr)
        ADR_CH0_SRC:  s_nxt.rdData = s_r.src[0];
        ADR_CH0_DST:  s_nxt.rdData = s_r.dst[0];
        ADR_CH0_CNT:  s_nxt.rdData = s_r.cnt[0];
        ADR_CH0_MODE: s_nxt.rdData = modeWord(s_r, 0);
        ADR_CH0_ACTL: s_nxt.rdData = actlWord(s_r, 0);
        ADR_CH1_SRC:  s_nxt.rdData = s_r.src[1];
        ADR_CH1_DST:  s_nxt.rdData = s_r.dst[1];
        ADR_CH1_CNT:  s_nxt.rdData = s_r.cnt[1];
        ADR_CH1_MODE: s_nxt.rdData = modeWord(s_r, 1);
        ADR_CH1_ACTL: s_nxt.rdData = actlWord(s_r, 1);
        ADR_CH0_RSEL: s_nxt.rdData = {24'h00_0000, s_r.reqSel[0]};
        ADR_CH1_RSEL: s_nxt.rdData = {24'h00_0000, s_r.reqSel[1]};
        ADR_SER_CTRL: s_nxt.rdData = {24'h00_0000, s_r.serCtrl};
        ADR_SER_STAT: begin
          s_nxt.rdData[B_TX_EMPTY] = s_r.txEmpty;
          s_nxt.rdData[B_RX_FULL]  = s_r.rxFull;
          s_nxt.rdData[B_OVERRUN]  = s_r.overrun;
          s_nxt.rdData[B_TX_END]   = s_r.txEnd;
          s_nxt.armFull = s_r.rxFull;
          s_nxt.armOver = s_r.overrun;
        end
        default: s_nxt.rdData = ZERO_WORD;
      endcase
    end

    // register writes; software clears come before hardware sets
    if (regWr) begin
      for (int c = 0; c < 2; c++) begin
        if (regAddr == (c == 0 ? ADR_CH0_SRC : ADR_CH1_SRC)) s_nxt.src[c] = wData;
        if (regAddr == (c == 0 ? ADR_CH0_DST : ADR_CH1_DST)) s_nxt.dst[c] = wData;
        if (regAddr == (c == 0 ? ADR_CH0_CNT : ADR_CH1_CNT)) s_nxt.cnt[c] = wData;
        if (regAddr == (c == 0 ? ADR_CH0_MODE : ADR_CH1_MODE)) begin
          // stopping a channel with work left counts as an escape
          if (s_r.go[c] && !wData[B_GO] && s_r.cnt[c] != ZERO_WORD)
            s_nxt.escFlag[c] = 1'b1;
          s_nxt.go[c]      = wData[B_GO];
          s_nxt.spacing[c] = wData[B_SPACING];
          if (!wData[B_ESC_FLAG])  s_nxt.escFlag[c]  = 1'b0;
          if (!wData[B_DONE_FLAG]) s_nxt.doneFlag[c] = 1'b0;
          if (s_r.go[c] && !wData[B_GO] && s_r.cnt[c] != ZERO_WORD)
            s_nxt.escFlag[c] = 1'b1;
          s_nxt.size[c]    = wData[B_SIZE+:2];
          s_nxt.xmode[c]   = wData[B_XMODE+:2];
          s_nxt.escOn[c]   = wData[B_ESC_ON];
          s_nxt.doneOn[c]  = wData[B_DONE_ON];
          s_nxt.actSrc[c]  = wData[B_ACT_SRC+:2];
          s_nxt.clrSrc[c]  = wData[B_CLR_SRC];
        end
        if (regAddr == (c == 0 ? ADR_CH0_ACTL : ADR_CH1_ACTL)) begin
          s_nxt.addr_mode_sel[c]     = wData[B_AMS];
          s_nxt.srcStep[c] = wData[B_SRC_STEP+:2];
          s_nxt.dstStep[c] = wData[B_DST_STEP+:2];
        end
        if (regAddr == (c == 0 ? ADR_CH0_RSEL : ADR_CH1_RSEL)) s_nxt.reqSel[c] = wData[7:0];
      end
      if (regAddr == ADR_SER_CTRL) begin
        s_nxt.serCtrl = wData[7:0];
        if (s_r.serCtrl[B_TX_ON] && !wData[B_TX_ON]) begin
          s_nxt.txEmpty = 1'b1;
          s_nxt.txEnd   = 1'b1;
        end
      end
      if (regAddr == ADR_SER_STAT) begin
        if (!wData[B_RX_FULL] && s_r.armFull) begin
          s_nxt.rxFull  = 1'b0;
          s_nxt.armFull = 1'b0;
        end
        if (!wData[B_OVERRUN] && s_r.armOver) begin
          s_nxt.overrun = 1'b0;
          s_nxt.armOver = 1'b0;
        end
        if (!wData[B_TX_EMPTY] && s_r.txEmpty) begin
          s_nxt.txEmpty = 1'b0;
          s_nxt.txEnd   = 1'b0;
        end
      end
    end

    // transfer engine: one channel at a time, channel 0 first
    case (s_r.fsm)
      SRDMA_IDLE: begin
        if (chReady[0] || chReady[1]) begin
          pick        = !chReady[0];
          s_nxt.cur   = pick;
          s_nxt.mAddr = s_r.src[pick];
          s_nxt.mRd   = s_r.src[pick] != ADR_RX_HOLD;
          s_nxt.fsm   = SRDMA_RD;
        end
      end
      SRDMA_RD: begin
        s_nxt.fsm = SRDMA_WR;
      end
      SRDMA_WR: begin
        // the byte from the source read lands this cycle
        if (s_r.src[s_r.cur] == ADR_RX_HOLD) begin
          rdByte = s_r.rxHold;
          if (s_r.clrSrc[s_r.cur]) s_nxt.rxFull = 1'b0;
        end else begin
          rdByte = memRdData;
        end
        s_nxt.data = rdByte;
        if (s_r.dst[s_r.cur] == ADR_TX_HOLD) begin
          s_nxt.txHold = rdByte;
          if (s_r.clrSrc[s_r.cur]) begin
            s_nxt.txEmpty = 1'b0;
            s_nxt.txEnd   = 1'b0;
          end
        end else begin
          s_nxt.mWr     = 1'b1;
          s_nxt.mWrData = rdByte;
        end
        s_nxt.mAddr = s_r.dst[s_r.cur];
        s_nxt.src[s_r.cur] = stepAddr(s_r.src[s_r.cur], s_r.srcStep[s_r.cur]);
        s_nxt.dst[s_r.cur] = stepAddr(s_r.dst[s_r.cur], s_r.dstStep[s_r.cur]);
        s_nxt.cnt[s_r.cur] = s_r.cnt[s_r.cur] - ONE_STEP;
        if (s_r.cnt[s_r.cur] == ONE_STEP) begin
          s_nxt.doneFlag[s_r.cur] = 1'b1;
          s_nxt.go[s_r.cur]       = 1'b0;
        end
        s_nxt.fsm = s_r.spacing[s_r.cur] ? SRDMA_GAP : SRDMA_IDLE;
      end
      SRDMA_GAP: begin
        s_nxt.fsm = SRDMA_IDLE;
      end
      default: s_nxt.fsm = SRDMA_IDLE;
    endcase

    // serial unit: receive side; the rx_on bit never touches the full flag
    if (rxDone && s_r.serCtrl[B_RX_ON]) begin
      if (s_r.rxFull) begin
        s_nxt.overrun = 1'b1;
      end else begin
        s_nxt.rxHold = rxByte;
        s_nxt.rxFull = 1'b1;
      end
    end
    // transmit side
    if (txTaken && s_r.serCtrl[B_TX_ON]) s_nxt.txEmpty = 1'b1;
    if (txLastBit && s_nxt.txEmpty) s_nxt.txEnd = 1'b1;

    // registered request and interrupt outputs
    s_nxt.reqOut[0] = txReqLive;
    s_nxt.reqOut[1] = rxReqLive;
    s_nxt.reqOut[2] = s_r.overrun && s_r.serCtrl[B_RX_IRQ];
    s_nxt.reqOut[3] = s_r.txEnd && s_r.serCtrl[B_TXEND_IRQ];
    for (int c = 0; c < 2; c++) begin
      s_nxt.doneIrq[c] = s_r.doneFlag[c] && s_r.doneOn[c];
      s_nxt.escIrq[c]  = s_r.escFlag[c] && s_r.escOn[c];
    end
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s_r         <= '0;
      s_r.txEmpty <= 1'b1;
      s_r.txEnd   <= 1'b1;
    end else if (clkEn) begin
      s_r <= s_nxt;
    end
  end

  assign regRdData  = s_r.rdData;
  assign memAddr    = s_r.mAddr;
  assign memRd      = s_r.mRd;
  assign memWr      = s_r.mWr;
  assign memWrData  = s_r.mWrData;
  assign txHoldData = s_r.txHold;
  assign txOn       = s_r.serCtrl[B_TX_ON];
  assign rxOn       = s_r.serCtrl[B_RX_ON];
  assign txEmptyReq = s_r.reqOut[0];
  assign rxFullReq  = s_r.reqOut[1];
  assign rxErrReq   = s_r.reqOut[2];
  assign txEndReq   = s_r.reqOut[3];
  assign chDoneIrq  = s_r.doneIrq;
  assign chEscIrq   = s_r.escIrq;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  sequence wrDone;
    clkEn && s_r.fsm == SRDMA_WR;
  endsequence
  sequence gapThenIdle;
    s_r.fsm == SRDMA_GAP ##1 (s_r.fsm == SRDMA_IDLE || !clkEn);
  endsequence

  a_spacing_gap: assert property (wrDone and s_r.spacing[s_r.cur] |=> gapThenIdle)
    else $error("spacing gap missing");
  a_done_flag_set: assert property (wrDone and s_r.cnt[s_r.cur] == ONE_STEP
    |=> s_r.doneFlag[$past(s_r.cur)] && !s_r.go[$past(s_r.cur)])
    else $error("count end did not set done flag");
  a_done_irq_gate: assert property (clkEn |=> chDoneIrq == $past(s_r.doneFlag & s_r.doneOn))
    else $error("done interrupt not gated");
  a_esc_irq_gate: assert property (clkEn |=> chEscIrq == $past(s_r.escFlag & s_r.escOn))
    else $error("escape interrupt not gated");
  a_read_then_write: assert property (clkEn && s_r.fsm == SRDMA_IDLE && (chReady != 2'b00)
    |=> s_r.fsm == SRDMA_RD && memAddr == $past(s_r.src[!chReady[0]]))
    else $error("transfer did not start with source read");
  a_count_step: assert property (wrDone |=> s_r.cnt[$past(s_r.cur)]
    == $past(s_r.cnt[s_r.cur]) - ONE_STEP)
    else $error("count not decremented");
  a_overrun_drop: assert property (clkEn && rxDone && rxOn && s_r.rxFull
    |=> s_r.overrun && s_r.rxHold == $past(s_r.rxHold))
    else $error("overrun did not hold old byte");
  a_rx_full_set: assert property (clkEn && rxDone && rxOn && !s_r.rxFull
    |=> s_r.rxFull && s_r.rxHold == $past(rxByte))
    else $error("reception not captured");
  a_tx_req_gate: assert property (clkEn && !s_r.serCtrl[B_TX_IRQ] |=> !txEmptyReq)
    else $error("transmit request not masked");
  a_stopped_idle: assert property (clkEn && s_r.fsm == SRDMA_IDLE && s_r.go == 2'b00
    |=> s_r.fsm != SRDMA_RD)
    else $error("stopped channel started a transfer");
endmodule : srdma_channels
`default_nettype wire

// [verification/srdma_far_end.sv]
`timescale 1ns/1ps
`default_nettype none
module srdma_far_end (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic [31:0] memAddr,
  input  wire logic        memRd,
  input  wire logic        memWr,
  input  wire logic [7:0]  memWrData,
  output logic      [7:0]  memRdData,
  input  wire logic        txEmptyReq,
  input  wire logic        txOn,
  output logic             rxDone,
  output logic      [7:0]  rxByte,
  output var logic         txTaken,
  output var logic         txLastBit
);
  // ****************
  // memory and shifter
  // ****************
  logic [7:0] mem [0:255];
  logic [7:0] q;
  logic       qv;
  logic [3:0] cnt;
  logic       armed;
  initial begin
    rxDone = 1'b0;
    rxByte = 8'h00;
  end
  // data off the answer cycle is inverted so a late sample cannot pass
  assign memRdData = qv ? q : ~q;
  // one character per 16 cycles; a request seen high and then low marks a load
  always @(posedge clk_sys) begin
    qv <= memRd;
    if (memRd) q <= mem[memAddr[7:0]];
    if (memWr) mem[memAddr[7:0]] <= memWrData;
    txTaken <= !rst && cnt == 4'h2;
    txLastBit <= !rst && cnt == 4'hc;
    if (rst) cnt <= 4'h0;
    else if (cnt != 4'h0 || (txOn && armed && !txEmptyReq)) cnt <= cnt + 4'h1;
    // the request lags the enable, so a low request alone is no proof of a load
    if (rst || (cnt == 4'h0 && txOn && !txEmptyReq)) armed <= 1'b0;
    else if (txEmptyReq) armed <= 1'b1;
  end
  task automatic send_rx(input logic [7:0] b);
    @(posedge clk_sys);
    rxDone <= 1'b1;
    rxByte <= b;
    @(posedge clk_sys);
    rxDone <= 1'b0;
    rxByte <= ~b;
  endtask : send_rx
endmodule : srdma_far_end
`default_nettype wire

// [verification/srdma_channels_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module srdma_channels_tb_top;
  import srdma_pkg::*;
  logic        clk_sys = 1'b0;
  logic        rst = 1'b1;
  logic        regWr = 1'b0;
  logic        regRd = 1'b0;
  logic [23:0] regAddr = 24'h00_0000;
  logic [31:0] regWrData = 32'h0;
  logic [31:0] regRdData, memAddr;
  logic        memRd, memWr, rxDone, txTaken, txLastBit, txOn, rxOn;
  logic        txEmptyReq, rxFullReq, rxErrReq, txEndReq;
  logic [7:0]  memWrData, memRdData, rxByte, txHoldData;
  logic [1:0]  chDoneIrq, chEscIrq;
  logic [7:0]  sent [$];
  int          fail_count = 0;
  int          n_checks = 0;
  int          i;
  always #12.5 clk_sys = ~clk_sys;
  srdma_channels dut (.clk_sys, .rst, .clkEn(1'b1), .regAddr, .regWrData, .regWr, .regRd,
    .regRdData, .memAddr, .memRd, .memWr, .memWrData, .memRdData, .rxDone, .rxByte,
    .txTaken, .txLastBit, .txHoldData, .txOn, .rxOn, .txEmptyReq, .rxFullReq, .rxErrReq,
    .txEndReq, .chDoneIrq, .chEscIrq);
  srdma_far_end far (.clk_sys, .rst, .memAddr, .memRd, .memWr, .memWrData, .memRdData,
    .txEmptyReq, .txOn, .rxDone, .rxByte, .txTaken, .txLastBit);
  always @(posedge clk_sys) if (txTaken) sent.push_back(txHoldData);
  // ****************
  // bus tasks
  // ****************
  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // the gap cycle keeps a strobe from being set twice in one step
  task wr(input logic [23:0] a, input logic [31:0] d);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge clk_sys);
    regWr <= 1'b0;
    @(posedge clk_sys);
  endtask : wr
  task rd(input logic [23:0] a, input logic [31:0] exp, input string nm);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk_sys);
    regRd <= 1'b0;
    @(posedge clk_sys);
    chk(nm, exp, regRdData);
  endtask : rd
  task wait_irq(input int ch);
    int k;
    for (k = 0; k < 3000 && chDoneIrq[ch] !== 1'b1; k++) @(posedge clk_sys);
    chk("done_wait", 32'h1, {31'h0, chDoneIrq[ch]});
  endtask : wait_irq
  task results;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : results
  initial begin
    #2_000_000;
    fail_count++;
    results();
  end
  // ****************
  // tests
  // ****************
  initial begin
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    wr(24'hff_fc10, 32'hffff_ffff);
    rd(24'hff_fc10, 32'h0, "unmapped");
    rd(ADR_SER_STAT, 32'h84, "stat_reset");
    rd(ADR_CH0_MODE, 32'h0, "mode_reset");
    $display("test reset done");
    for (i = 0; i < 4; i++) far.mem[8'h10 + i] = 8'ha0 + 8'(i);
    wr(ADR_SER_CTRL, 32'hf0);
    wr(ADR_CH0_SRC, 32'h10);
    wr(ADR_CH0_DST, ADR_TX_HOLD);
    wr(ADR_CH0_CNT, 32'h4);
    wr(ADR_CH0_ACTL, 32'h0020_0000);
    wr(ADR_CH0_RSEL, 32'h92);
    wr(ADR_CH0_MODE, 32'h8400_01a0);
    wait_irq(0);
    // the last byte leaves the holding register well after the count ends
    repeat (16) @(posedge clk_sys);
    chk("tx_count", 32'h4, sent.size());
    for (i = 0; i < 4; i++) chk("tx_byte", 32'ha0 + i, {24'h0, sent[i]});
    rd(ADR_CH0_CNT, 32'h0, "count_end");
    rd(ADR_CH0_SRC, 32'h14, "src_after");
    rd(ADR_CH0_MODE, 32'h0401_01a0, "mode_done");
    wr(ADR_CH0_MODE, 32'h0401_0000);
    rd(ADR_CH0_MODE, 32'h0401_0000, "flag_one");
    chk("done_masked", 32'h0, {31'h0, chDoneIrq[0]});
    wr(ADR_CH0_MODE, 32'h0);
    rd(ADR_CH0_MODE, 32'h0, "flag_zero");
    wr(ADR_SER_CTRL, 32'h74);
    repeat (3) @(posedge clk_sys);
    chk("tx_end_req", 32'h1, {31'h0, txEndReq});
    chk("tx_req_off", 32'h0, {31'h0, txEmptyReq});
    $display("test transmit done");
    wr(ADR_CH1_SRC, ADR_RX_HOLD);
    wr(ADR_CH1_DST, 32'h40);
    wr(ADR_CH1_CNT, 32'h2);
    wr(ADR_CH1_ACTL, 32'h0002_0000);
    wr(ADR_CH1_RSEL, 32'h91);
    wr(ADR_CH1_MODE, 32'h8000_01a0);
    far.send_rx(8'h5a);
    repeat (8) @(posedge clk_sys);
    far.send_rx(8'hc3);
    wait_irq(1);
    chk("rx_byte0", 32'h5a, {24'h0, far.mem[8'h40]});
    chk("rx_byte1", 32'hc3, {24'h0, far.mem[8'h41]});
    rd(ADR_CH1_DST, 32'h42, "dst_after");
    rd(ADR_CH1_SRC, ADR_RX_HOLD, "src_fixed");
    rd(ADR_SER_STAT, 32'h84, "rx_cleared");
    $display("test receive done");
    far.send_rx(8'h11);
    repeat (3) @(posedge clk_sys);
    far.send_rx(8'h22);
    repeat (3) @(posedge clk_sys);
    chk("err_req", 32'h1, {31'h0, rxErrReq});
    wr(ADR_SER_STAT, 32'h9f);
    wr(ADR_SER_CTRL, 32'ha4);
    rd(ADR_SER_STAT, 32'he4, "no_arm");
    chk("full_req_off", 32'h0, {31'h0, rxFullReq});
    chk("rx_off", 32'h0, {31'h0, rxOn});
    wr(ADR_SER_STAT, 32'h9f);
    rd(ADR_SER_STAT, 32'h84, "armed_clear");
    $display("test overrun done");
    wr(ADR_CH0_CNT, 32'h5);
    wr(ADR_CH0_MODE, 32'h8000_0200);
    wr(ADR_CH0_MODE, 32'h0000_0200);
    rd(ADR_CH0_MODE, 32'h0002_0200, "esc_flag");
    chk("esc_irq", 32'h1, {31'h0, chEscIrq[0]});
    rd(ADR_CH0_CNT, 32'h5, "no_activation");
    $display("test escape done");
    wr(ADR_CH0_SRC, 32'h10);
    wr(ADR_CH0_CNT, 32'h2);
    wr(ADR_CH0_MODE, 32'h8000_0180);
    wait_irq(0);
    chk("hold_last", 32'ha1, {24'h0, txHoldData});
    rd(ADR_SER_STAT, 32'h84, "src_kept");
    rd(ADR_CH0_DST, ADR_TX_HOLD, "dst_fixed");
    $display("test keep source done");
    results();
  end
endmodule : srdma_channels_tb_top
`default_nettype wire
